// >>> src/flash_status_cfg.svh
/*
  Opcodes, status bit positions and frame bit counts of the flash
  status register unit.
  Assumes it is included by its bare name after the package.
*/
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define OPC_READ_STATUS 8'h05
`define OPC_WRITE_LOW 8'h01
`define OPC_WRITE_HIGH 8'h31

// ----------------------------------------------------------------
// data byte bit positions
// ----------------------------------------------------------------
`define DAT_LOCK_BIT 7
`define DAT_PROT_BIT 2
`define DAT_RESET_CMD_ENABLE_BIT 4

// ----------------------------------------------------------------
// frame bit counts
// ----------------------------------------------------------------
`define OPC_BITS 5'h08
`define FRAME_FULL_BITS 5'h10
`define LAST_OPC_BIT 5'h07
`define LAST_DATA_BIT 5'h0F
`define STATUS_MSB 4'hF

// ----------------------------------------------------------------
// status word reset value: protect pin read as deasserted
// ----------------------------------------------------------------
`define STATUS_RST 16'h1000

`endif

// >>> src/flash_status_pkg.sv
/*
  Types of the flash status register unit: the two status bytes and
  the command snapshot passed from the serial link to the core.
  Assumes nothing of its surroundings.
*/
package flash_status_pkg;

  // ----------------------------------------------------------------
  // status bytes, bit 7 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lock;
    logic rsv6;
    logic fail;
    logic pin;
    logic rsv3;
    logic prot;
    logic write_enable_latch;
    logic busy;
  } sr_low_s;

  typedef struct packed {
    logic [2:0] rsv_hi;
    logic reset_cmd_enable;
    logic [2:0] rsv_lo;
    logic busy;
  } sr_high_s;

  typedef struct packed {
    sr_low_s low;
    sr_high_s high;
  } status_s;

  // ----------------------------------------------------------------
  // command snapshot left by the link at the end of a frame
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic op_full;
    logic data_ok;
  } frame_s;

endpackage : flash_status_pkg

// >>> src/flash_status_register_unit.sv
/*
  Status register unit of a serial flash: two status bytes, the read
  status stream and the two write status commands, plus the status
  side effects of array operations run elsewhere.
  Assumes an SPI host in mode 0 or 3 on i_spi_sck, i_cs_n, i_si and an
  array engine on i_core_clk that reports busy, done and fail.
*/
// Functional notes
// (R1) read status is opcode 05h; status follows on every later clock
// (R2) byte one bit 7..0 then byte two bit 7..0, repeated while selected
// (R3) status is sampled anew at the start of every two-byte repetition
// (R4) read status is served at any time, also while busy
// (R5) chip select high ends reading at any bit and floats the output
// (R6) lock set with protect pin asserted freezes the array protect bit
// (R7) lock bit is 0 after power-up
// (R8) with pin asserted lock may only go 0 to 1
// (R9) write status changes only byte-one bits 7 and 2; opcode 31h also writes byte-two bit 4
// (R10) fail flag follows the outcome of every program or erase
// (R11) aborted program or erase never sets the fail flag
// (R12) byte-one bit 4 reads 0 while pin asserted, else 1
// (R13) reserved bits read as 0
// (R14) array protect bit set rejects all program and erase
// (R15) write enable latch clear refuses writes; it resets to 0
// (R16) latch clears on write disable and completed or aborted writes; a granted program or erase and i_op_done leave it set
// (R17) incomplete or unknown opcodes leave the latch set
// (R18) busy bit reads 1 while busy, same in both bytes
// (R19) host polls fresh status until busy falls
// (R20) reset-enable bit powers up 0; reset command works only when 1
// (R21) reset-enable kept until rewritten; reset command leaves it
// (R22) opcode 01h plus one byte sets lock and protect at deselect
// (R23) opcode 31h plus one byte sets reset-enable at deselect
// (R24) output changes on falling clock, input sampled on rising
`timescale 1ns/1ps
`include "flash_status_cfg.svh"

module flash_status_register_unit
  import flash_status_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_spi_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic i_op_busy,
  input wire logic i_op_done,
  input wire logic i_op_fail,
  input wire logic i_array_req,
  input wire logic i_wel_set,
  input wire logic i_wel_clear,
  input wire logic i_reset_cmd,
  output logic o_so,
  output logic o_so_oe,
  output status_s o_status,
  output logic o_write_enable,
  output logic o_array_protect,
  output logic o_reset_enable,
  output logic o_array_grant,
  output logic o_array_refuse,
  output logic o_soft_reset
);

  // ----------------------------------------------------------------
  // link domain: serial input, frame snapshot
  // ----------------------------------------------------------------
  logic link_rst_n;
  logic [4:0] cnt_reg, cnt_next;
  logic [2:0] mod_reg, mod_next;
  logic [6:0] sh_reg;
  logic [7:0] op_reg, dat_reg;
  logic full_reg, ok_reg, tog_reg, rd_en;

  // bit counters and stream output are cleared whenever chip select is high
  assign link_rst_n = i_arst_n & ~i_cs_n; // R5
  assign mod_next = mod_reg + 3'h1;
  assign cnt_next = (cnt_reg == `FRAME_FULL_BITS) ? cnt_reg
                    : cnt_reg + 5'h01;
  assign rd_en = (cnt_reg >= `OPC_BITS)
                 && (op_reg == `OPC_READ_STATUS); // R1 R4

  // bit counters of the current frame
  always_ff @(posedge i_spi_sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cnt_reg <= 5'h00;
      mod_reg <= 3'h0;
    end
    else
    begin
      cnt_reg <= cnt_next; // R24
      mod_reg <= mod_next;
    end
  end

  // opcode and data byte capture, msb first
  always_ff @(posedge i_spi_sck or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sh_reg <= 7'h00;
      op_reg <= 8'h00;
      dat_reg <= 8'h00;
    end
    else
    begin
      sh_reg <= {sh_reg[5:0], i_si}; // R24
      if (cnt_reg == `LAST_OPC_BIT)
        op_reg <= {sh_reg, i_si};
      if (cnt_reg == `LAST_DATA_BIT)
        dat_reg <= {sh_reg, i_si}; // R22 R23
    end
  end

  // frame length flags survive deselect for the core to read
  always_ff @(posedge i_spi_sck or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      full_reg <= 1'b0;
      ok_reg <= 1'b0;
      tog_reg <= 1'b0;
    end
    else
    begin
      full_reg <= (cnt_next >= `OPC_BITS); // R17
      ok_reg <= (cnt_next == `FRAME_FULL_BITS) && (mod_next == 3'h0);
      if (cnt_reg == 5'h00)
        tog_reg <= ~tog_reg; // marks a new frame
    end
  end

  // ----------------------------------------------------------------
  // link domain: status stream out
  // ----------------------------------------------------------------
  status_s st_meta_reg, st_sync_reg;
  status_s word_reg, status_reg;
  logic [3:0] idx_reg;

  // status word carried into the link clock, bit by bit as levels
  always_ff @(posedge i_spi_sck or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_meta_reg <= '0;
      st_sync_reg <= '0;
    end
    else
    begin
      st_meta_reg <= status_reg;
      st_sync_reg <= st_meta_reg;
    end
  end

  // shift out on falling edges; snapshot at every repetition start
  always_ff @(negedge i_spi_sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      idx_reg <= 4'h0;
      word_reg <= '0;
      o_so <= 1'b0;
      o_so_oe <= 1'b0; // R5
    end
    else if (rd_en)
    begin
      o_so_oe <= 1'b1;
      idx_reg <= idx_reg + 4'h1; // R2
      if (idx_reg == 4'h0)
      begin
        word_reg <= st_sync_reg; // R3
        word_reg.high.busy <= st_sync_reg.low.busy; // R18
        o_so <= st_sync_reg[`STATUS_MSB];
      end
      else
        o_so <= word_reg[`STATUS_MSB - idx_reg]; // R2 R24
    end
  end

  // ----------------------------------------------------------------
  // core domain: pin synchronisers and frame end detection
  // ----------------------------------------------------------------
  logic [1:0] cs_sync_reg, wp_sync_reg, tog_sync_reg;
  logic cs_seen_reg, tog_seen_reg;
  logic new_frame, wp_on;
  frame_s frame;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cs_sync_reg <= 2'h3;
      wp_sync_reg <= 2'h3;
      tog_sync_reg <= 2'h0;
      cs_seen_reg <= 1'b1;
      tog_seen_reg <= 1'b0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
      wp_sync_reg <= {wp_sync_reg[0], i_wp_n};
      tog_sync_reg <= {tog_sync_reg[0], tog_reg};
      cs_seen_reg <= cs_sync_reg[1];
      if (new_frame)
        tog_seen_reg <= tog_sync_reg[1];
    end
  end

  // frame words are still while chip select is high
  assign new_frame = cs_sync_reg[1] && !cs_seen_reg
                     && (tog_sync_reg[1] != tog_seen_reg);
  assign wp_on = ~wp_sync_reg[1];
  assign frame = '{opcode: op_reg, data: dat_reg,
                   op_full: full_reg, data_ok: ok_reg};

  // ----------------------------------------------------------------
  // core domain: command decode
  // ----------------------------------------------------------------
  logic lock_reg, prot_reg, wel_reg, fail_reg, busy_reg, reset_cmd_enable_reg;
  logic wr_low, wr_high, low_apply, high_apply, grant_ok, wel_drop;

  assign wr_low = new_frame && frame.op_full
                  && (frame.opcode == `OPC_WRITE_LOW); // R22
  assign wr_high = new_frame && frame.op_full
                   && (frame.opcode == `OPC_WRITE_HIGH); // R23
  // locked state with pin asserted keeps lock and protect, including against a lock clear
  assign low_apply = wr_low && frame.data_ok && wel_reg
                     && !(lock_reg && wp_on); // R6 R8 R15
  assign high_apply = wr_high && frame.data_ok && wel_reg; // R15
  assign grant_ok = wel_reg && !prot_reg && !busy_reg; // R14 R15
  assign wel_drop = wr_low || wr_high || i_wel_clear
                    || (i_array_req && !grant_ok)
                    || (i_reset_cmd && reset_cmd_enable_reg); // R16 R17

  // ----------------------------------------------------------------
  // core domain: status bits
  // ----------------------------------------------------------------
  // lock and array protect, written by the first write status
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lock_reg <= 1'b0; // R7
      prot_reg <= 1'b0;
    end
    else if (low_apply)
    begin
      lock_reg <= frame.data[`DAT_LOCK_BIT]; // R9
      prot_reg <= frame.data[`DAT_PROT_BIT]; // R9
    end
  end

  // reset-enable, only the second write status touches it
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      reset_cmd_enable_reg <= 1'b0; // R20
    else if (high_apply)
      reset_cmd_enable_reg <= frame.data[`DAT_RESET_CMD_ENABLE_BIT]; // R21
  end

  // write enable latch; a set in the same cycle wins
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      wel_reg <= 1'b0; // R15
    else if (i_wel_set)
      wel_reg <= 1'b1;
    else if (wel_drop)
      wel_reg <= 1'b0; // R16
  end

  // fail flag refreshed by each finished operation only
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fail_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= i_op_busy; // R18
      if (i_op_done)
        fail_reg <= i_op_fail; // R10 R11
    end
  end

  // status word assembly
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      status_reg <= `STATUS_RST; // pin bit agrees with its synchroniser
    else
    begin
      status_reg.low <= '{lock: lock_reg, rsv6: 1'b0, fail: fail_reg,
                          pin: ~wp_on, rsv3: 1'b0, prot: prot_reg,
                          write_enable_latch: wel_reg, busy: busy_reg}; // R12 R13
      status_reg.high <= '{rsv_hi: 3'h0, reset_cmd_enable: reset_cmd_enable_reg,
                           rsv_lo: 3'h0, busy: busy_reg}; // R13 R18
    end
  end

  // ----------------------------------------------------------------
  // core domain: outputs to the array engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_array_grant <= 1'b0;
      o_array_refuse <= 1'b0;
      o_soft_reset <= 1'b0;
      o_write_enable <= 1'b0;
      o_array_protect <= 1'b0;
      o_reset_enable <= 1'b0;
      o_status <= '0;
    end
    else
    begin
      o_array_grant <= i_array_req && grant_ok; // R14
      o_array_refuse <= i_array_req && !grant_ok; // R14 R15
      o_soft_reset <= i_reset_cmd && reset_cmd_enable_reg; // R20
      o_write_enable <= wel_reg;
      o_array_protect <= prot_reg;
      o_reset_enable <= reset_cmd_enable_reg;
      o_status <= status_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_lock_clear_pin: assert property (@(posedge i_core_clk) // R8
    disable iff (!i_arst_n) $fell(lock_reg) |-> $past(wp_sync_reg[1]))
    else $error("lock cleared while protect pin asserted");

  a_protect_frozen: assert property (@(posedge i_core_clk) // R6
    disable iff (!i_arst_n) (lock_reg && wp_on) |=> $stable(prot_reg))
    else $error("array protect changed while locked");

  a_pin_level: assert property (@(posedge i_core_clk) // R12
    disable iff (!i_arst_n)
    status_reg.low.pin == $past(wp_sync_reg[1]))
    else $error("pin status bit does not follow pin");

  a_reserved_zero: assert property (@(posedge i_core_clk) // R13
    disable iff (!i_arst_n) !status_reg.low.rsv6 && !status_reg.low.rsv3
    && (status_reg.high.rsv_hi == 3'h0)
    && (status_reg.high.rsv_lo == 3'h0))
    else $error("reserved status bit set");

  a_busy_both: assert property (@(posedge i_core_clk) // R18
    disable iff (!i_arst_n) ##2 (status_reg.low.busy == $past(i_op_busy, 2))
    && (status_reg.high.busy == status_reg.low.busy))
    else $error("busy bit wrong or bytes differ");

  a_fail_refresh: assert property (@(posedge i_core_clk) // R10
    disable iff (!i_arst_n)
    i_op_done |-> ##2 (status_reg.low.fail == $past(i_op_fail, 2)))
    else $error("fail flag not refreshed");

  a_refuse_keep_fail: assert property (@(posedge i_core_clk) // R11
    disable iff (!i_arst_n)
    (i_array_req && !grant_ok && !i_op_done) |=> $stable(fail_reg))
    else $error("fail flag moved on an abort");

  a_wel_refuse: assert property (@(posedge i_core_clk) // R15
    disable iff (!i_arst_n)
    (i_array_req && !wel_reg) |=> o_array_refuse && !o_array_grant)
    else $error("array write granted without latch");

  a_wel_abort_clear: assert property (@(posedge i_core_clk) // R16
    disable iff (!i_arst_n) (wel_drop && !i_wel_set) |=> !wel_reg)
    else $error("latch not cleared on completion or abort");

  a_reset_cmd_enable_kept: assert property (@(posedge i_core_clk) // R21
    disable iff (!i_arst_n) (i_reset_cmd && !high_apply) |=> $stable(reset_cmd_enable_reg))
    else $error("reset command changed reset-enable");

  a_reset_gated: assert property (@(posedge i_core_clk) // R20
    disable iff (!i_arst_n) (i_reset_cmd && !reset_cmd_enable_reg) |=> !o_soft_reset)
    else $error("reset honoured while disabled");

  a_float_deselect: assert property (@(posedge i_core_clk) // R5
    disable iff (!i_arst_n) cs_sync_reg[1] |-> !o_so_oe)
    else $error("output driven while deselected");

  c_read_status: cover property (@(posedge i_core_clk)
    disable iff (!i_arst_n) $rose(o_so_oe));
  c_write_low: cover property (@(posedge i_core_clk)
    disable iff (!i_arst_n) low_apply);
  c_write_high: cover property (@(posedge i_core_clk)
    disable iff (!i_arst_n) high_apply);
  c_refuse: cover property (@(posedge i_core_clk)
    disable iff (!i_arst_n) o_array_refuse);

endmodule : flash_status_register_unit

// >>> test/spi_host_model.sv
/*
  SPI host model for the flash status register unit: mode 0 frames.
  Assumes the bench calls its tasks and leaves idle time between frames.
*/
`timescale 1ns/1ps

module spi_host_model
(
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  // ----------------------------------------------------------------
  // bit level
  // ----------------------------------------------------------------
  // clock idles low and stands still outside frames
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // data set while clock low, reply taken just before the rising edge
  task automatic bit_io(input logic b, output logic r);
    o_si = b;
    #6;
    r = i_so_oe ? i_so : 1'bx;
    o_sck = 1'b1;
    #6;
    o_sck = 1'b0;
  endtask : bit_io

  // deselect; the data line shows the inverse of its last value
  task automatic frame_end();
    #6;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #2;
  endtask : frame_end

  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  // send the top nbits of tx, msb first
  task automatic send(input logic [15:0] tx, input int nbits);
    logic r;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      bit_io(tx[15 - i], r);
    end
    frame_end();
  endtask : send

  // read status opcode, then nbits of stream into the low end of rx
  task automatic read_status(input int nbits, output logic [47:0] rx);
    logic [7:0] opc;
    logic r;
    opc = 8'h05;
    rx = '0;
    o_cs_n = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(opc[7 - i], r);
    end
    for (int i = 0; i < nbits; i++)
    begin
      bit_io(~o_si, r);
      rx = {rx[46:0], r};
    end
    frame_end();
  endtask : read_status
endmodule : spi_host_model

// >>> test/flash_status_register_unit_tb_top.sv
/*
  Testbench of the flash status register unit: SPI frames through the
  host model plus core pulses, with expected status values.
  Assumes the package, the design and spi_host_model are compiled first.
*/
`timescale 1ns/1ps

module flash_status_register_unit_tb_top
  import flash_status_pkg::*;
();
  logic core_clk, arst_n, wp_n, op_busy, op_done, op_fail;
  logic array_req, wel_set, wel_clear, reset_cmd;
  logic sck, cs_n, si, so, so_oe, write_enable, array_protect;
  logic reset_enable, grant, refuse, soft_reset, g, r, s;
  status_s status;
  logic [47:0] rx;
  int err_total, comparisons;

  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  always #20 core_clk = ~core_clk;

  flash_status_register_unit i_dut (
    .i_core_clk(core_clk), .i_arst_n(arst_n), .i_spi_sck(sck),
    .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n), .i_op_busy(op_busy),
    .i_op_done(op_done), .i_op_fail(op_fail), .i_array_req(array_req),
    .i_wel_set(wel_set), .i_wel_clear(wel_clear),
    .i_reset_cmd(reset_cmd), .o_so(so), .o_so_oe(so_oe),
    .o_status(status), .o_write_enable(write_enable),
    .o_array_protect(array_protect), .o_reset_enable(reset_enable),
    .o_array_grant(grant), .o_array_refuse(refuse),
    .o_soft_reset(soft_reset)
  );

  spi_host_model i_host (
    .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  // one-cycle pulse on {array_req, wel_set, wel_clear, reset_cmd}
  task automatic pulse(input logic [3:0] sel);
    idle(1);
    {array_req, wel_set, wel_clear, reset_cmd} = sel;
    idle(1);
    {array_req, wel_set, wel_clear, reset_cmd} = 4'h0;
    {g, r, s} = {grant, refuse, soft_reset};
  endtask : pulse

  // set the latch, then one full write frame
  task automatic wr(input logic [15:0] cmd);
    pulse(4'h4);
    idle(2);
    i_host.send(cmd, 16);
    idle(10);
  endtask : wr

  task automatic close_out();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #2000000;
    err_total++;
    $display("timeout at %0t", $time);
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {core_clk, arst_n, op_busy, op_done, op_fail} = 5'h00;
    {array_req, wel_set, wel_clear, reset_cmd} = 4'h0;
    wp_n = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    idle(6);
    chk(status, 32'h1000);
    i_host.read_status(32, rx);
    chk(rx[31:0], 32'h10001000);
    pulse(4'h4);
    idle(2);
    chk(write_enable, 32'h1);
    i_host.read_status(32, rx);
    chk(rx[31:0], 32'h12001200);
    idle(4);
    i_host.send(16'h01FF, 16);
    idle(10);
    chk(status, 32'h9400);
    chk(array_protect, 32'h1);
    pulse(4'h4);
    idle(2);
    pulse(4'h8);
    chk({g, r}, 32'h1);
    idle(2);
    chk(write_enable, 32'h0);
    wp_n = 1'b0;
    idle(6);
    chk(status, 32'h8400);
    wr(16'h0100);
    chk(status, 32'h8400);
    wp_n = 1'b1;
    idle(6);
    wr(16'h0100);
    chk(status, 32'h1000);
    pulse(4'h4);
    idle(2);
    i_host.send(16'h0100, 4);
    idle(10);
    i_host.send(16'hA500, 16);
    idle(10);
    chk(write_enable, 32'h1);
    pulse(4'h8);
    chk({g, r}, 32'h2);
    pulse(4'h2);
    idle(2);
    chk(write_enable, 32'h0);
    pulse(4'h8);
    chk({g, r}, 32'h1);
    // busy drops while the stream runs
    op_busy = 1'b1;
    idle(6);
    fork
      i_host.read_status(48, rx);
      begin
        idle(4);
        op_busy = 1'b0;
      end
    join
    idle(1);
    chk(rx[47:32], 32'h1101);
    chk(rx[15:0], 32'h1000);
    // outcome of array operations
    {op_done, op_fail} = 2'b11;
    idle(1);
    {op_done, op_fail} = 2'b00;
    idle(4);
    chk(status, 32'h3000);
    op_done = 1'b1;
    idle(1);
    op_done = 1'b0;
    idle(4);
    chk(status, 32'h1000);
    pulse(4'h8);
    idle(4);
    chk(status, 32'h1000);
    // reset command gated by reset-enable
    pulse(4'h1);
    chk(s, 32'h0);
    wr(16'h3110);
    chk(status, 32'h1010);
    pulse(4'h1);
    chk(s, 32'h1);
    idle(2);
    chk(reset_enable, 32'h1);
    // second write without latch, then a first write cut in mid-byte
    i_host.send(16'h31EF, 16);
    idle(10);
    pulse(4'h4);
    idle(2);
    i_host.send(16'h01FF, 12);
    idle(10);
    chk(status, 32'h1010);
    chk(write_enable, 32'h0);
    // deselect in mid-byte
    i_host.read_status(5, rx);
    chk(so_oe, 32'h0);
    chk(rx[4:0], 32'h02);
    close_out();
  end
endmodule : flash_status_register_unit_tb_top
